// File: src/dpl_pkg.sv
// Purpose: constants and types for the debug port lock block
// Assumes: 25 MHz system clock, Avalon-MM slave with 32-bit data
// Notes: register offsets are byte addresses
// Functional notes
// - The lock output is 1 when at least 28 of the 32 latch bits match the pattern.
// - While the sampled lock is 1, every debug, test and programming port stays off.
// - Once the latch matches, committing or erasing the latch is refused.
// - The latch is sampled only at reset release and held until the next reset.
// - A key write is accepted only while the flash protection level is zero.
// - After the key is written, port access continues until the next reset.
// - The latch contents stay readable so a host can identify a locked part.
// - Protection levels only rise; only a full device erase brings them down.
// - A block erase, program or verify runs only if that block's security bit allows it.
// - The whole device can be erased and verified over either debug port.
// - Only serial-wire with single-pin trace or parallel trace, or scan with parallel trace.
// - Parallel trace takes 5 pins, single-pin trace 1 pin shared with a scan pin.
package dpl_pkg;
  localparam logic [4:0] OFS_PORT_CFG = 5'h00;
  localparam logic [4:0] OFS_KEY_STAGE = 5'h04;
  localparam logic [4:0] OFS_CMD = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_LATCH = 5'h10;
  localparam logic [4:0] OFS_BLK_SEC = 5'h14;
  // arbitrary pattern value, not taken from any part
  localparam logic [31:0] LOCK_PATTERN = 32'hA5C396E1;
  localparam logic [5:0] MATCH_MIN = 6'h1C;
  localparam int TRACE_PINS = 5;
  localparam int PIN_TRACE_PINS = 1;
  localparam int CFG_JTAG = 0;
  localparam int CFG_SWD = 1;
  localparam int CFG_PIN_TRACE = 2;
  localparam int CFG_TRACE = 3;
  localparam int CMD_COMMIT = 0;
  localparam int CMD_LERASE = 1;
  localparam int CMD_FLASH = 2;
  localparam int CMD_PROT = 3;
  localparam int CMD_OP_LSB = 4;
  localparam int CMD_LVL_LSB = 8;
  localparam int CMD_BLK_LSB = 12;
  localparam logic [3:0] CFG_RST = 4'h1;
  localparam logic [15:0] BLK_SEC_RST = 16'hFFFF;
  typedef enum logic [2:0] {
    OP_FULL_ERASE = 3'b000,
    OP_FULL_PROG = 3'b001,
    OP_FULL_VERIFY = 3'b010,
    OP_BLK_ERASE = 3'b100,
    OP_BLK_PROG = 3'b101,
    OP_BLK_VERIFY = 3'b110
  } dpl_op_t;
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic sampled;
    logic locked;
    logic [3:0] cfg;
    logic [31:0] stage;
    logic [15:0] blk_sec;
    logic refused;
    logic nv_prog;
    logic nv_erase;
    logic op_stb;
    logic [2:0] op;
    logic [3:0] blk;
    logic prot_set;
    logic [1:0] prot_lvl;
    logic [3:0] ports;
    logic pair_err;
  } dpl_state_t;
endpackage

// File: src/dpl_lock.sv
// Purpose: access lock, flash command gate and debug/trace port enables
// Assumes: nonvolatile latch and flash live outside; their levels are synchronous inputs
// Notes: one-cycle waitrequest; writes take effect when waitrequest is low
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
module dpl_lock
  import dpl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [31:0] latch_nv_i,
  input wire logic [1:0] prot_level_i,
  output logic [31:0] latch_data_o,
  output logic latch_prog_o,
  output logic latch_erase_o,
  output logic flash_op_stb_o,
  output logic [2:0] flash_op_o,
  output logic [3:0] flash_blk_o,
  output logic prot_set_o,
  output logic [1:0] prot_level_o,
  output logic jtag_en_o,
  output logic swd_en_o,
  output logic pin_trace_en_o,
  output logic trace_en_o
);
  dpl_state_t st;
  dpl_state_t nxt_st;
  logic [31:0] hit;
  logic latch_match;

  // per-bit agreement with the pattern
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_hit
      assign hit[gi] = (latch_nv_i[gi] == LOCK_PATTERN[gi]);
    end
  endgenerate

  function automatic logic [5:0] popcnt(input logic [31:0] v);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 32; i++) begin
      c = c + {5'h00, v[i]};
    end
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign latch_match = (popcnt(hit) >= MATCH_MIN);

  always_comb begin
    logic req;
    logic wr;
    logic open_acc;
    logic [3:0] want;
    logic [1:0] lvl;
    logic [2:0] op;
    logic [3:0] blk;
    logic [31:0] mrg;
    req = 1'b0;
    wr = 1'b0;
    open_acc = 1'b0;
    want = 4'h0;
    lvl = 2'h0;
    op = 3'h0;
    blk = 4'h0;
    mrg = 32'h0;
    nxt_st = st;
    nxt_st.nv_prog = 1'b0;
    nxt_st.nv_erase = 1'b0;
    nxt_st.op_stb = 1'b0;
    nxt_st.prot_set = 1'b0;
    // lock level caught once, in the first cycle after reset release
    if (!st.sampled) begin
      nxt_st.sampled = 1'b1;
      nxt_st.locked = latch_match;
    end
    req = avs_read_i | avs_write_i;
    nxt_st.waitreq = !(req && st.waitreq);
    wr = avs_write_i && !st.waitreq;
    // debug access open only after sampling and while unlocked
    open_acc = st.sampled && !st.locked;
    if (req && st.waitreq) begin
      if (avs_address_i == OFS_PORT_CFG) begin
        nxt_st.rdata = {28'h0, st.cfg};
      end else if (avs_address_i == OFS_KEY_STAGE) begin
        nxt_st.rdata = st.stage;
      end else if (avs_address_i == OFS_STATUS) begin
        nxt_st.rdata = {22'h0, st.pair_err, prot_level_i, st.refused,
                        st.ports, latch_match, st.locked};
      end else if (avs_address_i == OFS_LATCH) begin
        nxt_st.rdata = latch_nv_i;
      end else if (avs_address_i == OFS_BLK_SEC) begin
        nxt_st.rdata = {16'h0, st.blk_sec};
      end else begin
        nxt_st.rdata = 32'h0;
      end
    end
    if (wr) begin
      if (!open_acc) begin
        nxt_st.refused = 1'b1;
      end else if (avs_address_i == OFS_PORT_CFG) begin
        mrg = merge({28'h0, st.cfg}, avs_writedata_i, avs_byteenable_i);
        nxt_st.cfg = mrg[3:0];
      end else if (avs_address_i == OFS_BLK_SEC) begin
        mrg = merge({16'h0, st.blk_sec}, avs_writedata_i, avs_byteenable_i);
        nxt_st.blk_sec = mrg[15:0];
      end else if (avs_address_i == OFS_KEY_STAGE) begin
        if (prot_level_i == 2'h0) begin
          nxt_st.stage = merge(st.stage, avs_writedata_i, avs_byteenable_i);
        end else begin
          nxt_st.refused = 1'b1;
        end
      end else if (avs_address_i == OFS_CMD) begin
        nxt_st.refused = 1'b0;
        lvl = avs_writedata_i[CMD_LVL_LSB +: 2];
        op = avs_writedata_i[CMD_OP_LSB +: 3];
        blk = avs_writedata_i[CMD_BLK_LSB +: 4];
        // the key in the stage reaches the cells only by commit
        if (avs_writedata_i[CMD_COMMIT] || avs_writedata_i[CMD_LERASE]) begin
          if (latch_match || prot_level_i != 2'h0) begin
            nxt_st.refused = 1'b1;
          end else begin
            nxt_st.nv_prog = avs_writedata_i[CMD_COMMIT];
            nxt_st.nv_erase = avs_writedata_i[CMD_LERASE];
          end
        end
        if (avs_writedata_i[CMD_FLASH]) begin
          if (op[2] && !st.blk_sec[blk]) begin
            nxt_st.refused = 1'b1;
          end else if (op == 3'b011 || op == 3'b111) begin
            nxt_st.refused = 1'b1;
          end else begin
            nxt_st.op_stb = 1'b1;
            nxt_st.op = op;
            nxt_st.blk = blk;
          end
        end
        if (avs_writedata_i[CMD_PROT]) begin
          if (lvl > prot_level_i) begin
            nxt_st.prot_set = 1'b1;
            nxt_st.prot_lvl = lvl;
          end else begin
            nxt_st.refused = 1'b1;
          end
        end
      end
    end
    // port enables follow the held lock and the legal pairings
    want = nxt_st.cfg;
    nxt_st.pair_err = 1'b0;
    if (want[CFG_JTAG] && want[CFG_SWD]) begin
      want[CFG_SWD] = 1'b0;
      nxt_st.pair_err = 1'b1;
    end
    if (want[CFG_JTAG] && want[CFG_PIN_TRACE]) begin
      want[CFG_PIN_TRACE] = 1'b0;
      nxt_st.pair_err = 1'b1;
    end
    if (want[CFG_PIN_TRACE] && want[CFG_TRACE]) begin
      want[CFG_PIN_TRACE] = 1'b0;
      nxt_st.pair_err = 1'b1;
    end
    if (!nxt_st.sampled || nxt_st.locked) begin
      nxt_st.ports = 4'h0;
    end else begin
      nxt_st.ports = want;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.cfg <= CFG_RST;
      st.blk_sec <= BLK_SEC_RST;
    end else begin
      st <= nxt_st;
    end
  end

  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = st.waitreq;
  assign latch_data_o = st.stage;
  assign latch_prog_o = st.nv_prog;
  assign latch_erase_o = st.nv_erase;
  assign flash_op_stb_o = st.op_stb;
  assign flash_op_o = st.op;
  assign flash_blk_o = st.blk;
  assign prot_set_o = st.prot_set;
  assign prot_level_o = st.prot_lvl;
  assign jtag_en_o = st.ports[CFG_JTAG];
  assign swd_en_o = st.ports[CFG_SWD];
  assign pin_trace_en_o = st.ports[CFG_PIN_TRACE];
  assign trace_en_o = st.ports[CFG_TRACE];

  a_lock_from_match: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(st.sampled) |-> st.locked == $past(latch_match))
    else $error("lock level differs from latch vote");

  a_ports_off_locked: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    st.locked |-> !(jtag_en_o || swd_en_o || pin_trace_en_o || trace_en_o))
    else $error("port enabled while locked");

  a_no_latch_change: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (latch_prog_o || latch_erase_o) |-> !$past(latch_match))
    else $error("latch changed after match");

  a_lock_held: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(st.sampled) |-> $stable(st.locked))
    else $error("lock level moved between resets");

  a_key_prot_gate: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    $changed(st.stage) |-> $past(prot_level_i) == 2'h0)
    else $error("key taken with protection set");

  a_open_after_key: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    latch_prog_o |-> !st.locked ##1 !st.locked)
    else $error("lock took effect before reset");

  a_prot_rise_only: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    prot_set_o |-> prot_level_o > $past(prot_level_i))
    else $error("protection level lowered");

  a_blk_sec_gate: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (flash_op_stb_o && flash_op_o[2]) |-> st.blk_sec[flash_blk_o])
    else $error("block op without block permission");

  a_full_op_open: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    flash_op_stb_o |-> $past(st.sampled && !st.locked))
    else $error("flash op while closed");

  a_scan_swd_pair: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    !(jtag_en_o && swd_en_o) && !(pin_trace_en_o && trace_en_o))
    else $error("illegal debug pairing");

  a_pin_trace_scan: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    !(pin_trace_en_o && jtag_en_o))
    else $error("single-pin trace with scan");

  a_normal_enable: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (st.sampled && !st.locked && st.cfg[CFG_TRACE]) |-> trace_en_o)
    else $error("unlocked port not following config");

  a_ports_before_sample: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    !st.sampled |-> !(jtag_en_o || swd_en_o || pin_trace_en_o || trace_en_o))
    else $error("port enabled before lock sampled");

  a_write_refused_locked: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (avs_write_i && !avs_waitrequest_o && st.locked) |=> st.refused)
    else $error("write not refused while locked");

  a_nv_quiet_locked: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    st.locked |-> !(latch_prog_o || latch_erase_o))
    else $error("latch command while locked");

  a_key_refused: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_KEY_STAGE
      && prot_level_i != 2'h0) |=> $stable(st.stage))
    else $error("key stage moved with protection set");

  a_blk_op_refused: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_CMD && st.sampled
      && !st.locked && avs_writedata_i[CMD_FLASH] && avs_writedata_i[CMD_OP_LSB + 2]
      && !st.blk_sec[avs_writedata_i[CMD_BLK_LSB +: 4]])
      |=> (!flash_op_stb_o && st.refused))
    else $error("block op not refused");

  a_jtag_follows: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (st.sampled && !st.locked && st.cfg[CFG_JTAG]) |-> jtag_en_o)
    else $error("scan port not following config");
endmodule

// File: verif/dpl_nv_model.sv
// Purpose: latch cells and protection store beside the lock block
// Assumes: commands arrive as one-cycle pulses
// Notes: load_i presets the cells and clears protection
`timescale 1ns/10ps
module dpl_nv_model
  import dpl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  input wire logic prog_i,
  input wire logic erase_i,
  input wire logic [31:0] data_i,
  input wire logic op_stb_i,
  input wire logic [2:0] op_i,
  input wire logic prot_set_i,
  input wire logic [1:0] prot_lvl_i,
  output logic [31:0] cells_o,
  output logic [1:0] prot_o
);
  always @(posedge clk_sys_i) begin
    if (load_i) begin
      cells_o <= load_val_i;
      prot_o <= 2'h0;
    end else begin
      if (prog_i) cells_o <= data_i;
      else if (erase_i) cells_o <= 32'h0;
      if (prot_set_i) prot_o <= prot_lvl_i;
      else if (op_stb_i && op_i == OP_FULL_ERASE) prot_o <= 2'h0;
    end
  end
endmodule

// File: verif/debug_port_security_lock_tb_top.sv
// Purpose: register-level bench for the debug port lock
// Assumes: bus waits on waitrequest, each wait bounded
// Notes: cells and protection level come from the nv model
`timescale 1ns/10ps
module debug_port_security_lock_tb_top
  import dpl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic ld = 1'b1;
  logic [31:0] ldv = 32'h0;
  logic [31:0] rdat, nv, ldat, q;
  logic [1:0] plv, prq;
  logic [2:0] fop;
  logic [3:0] fblk;
  logic wrq, lpg, ler, stb, pst, je, se, ve, te;
  int err_count = 0;
  int check_count = 0;
  int stb_n = 0;
  int er_n = 0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (stb === 1'b1) stb_n <= stb_n + 1;
    if (ler === 1'b1) er_n <= er_n + 1;
  end
  dpl_lock dut_u (.clk_sys_i(clk), .rst_b_i(rst_b), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
    .latch_nv_i(nv), .prot_level_i(plv), .latch_data_o(ldat),
    .latch_prog_o(lpg), .latch_erase_o(ler), .flash_op_stb_o(stb),
    .flash_op_o(fop), .flash_blk_o(fblk), .prot_set_o(pst),
    .prot_level_o(prq), .jtag_en_o(je), .swd_en_o(se), .pin_trace_en_o(ve),
    .trace_en_o(te));
  dpl_nv_model nv_u (.clk_sys_i(clk), .load_i(ld), .load_val_i(ldv),
    .prog_i(lpg), .erase_i(ler), .data_i(ldat), .op_stb_i(stb), .op_i(fop),
    .prot_set_i(pst), .prot_lvl_i(prq), .cells_o(nv), .prot_o(plv));
  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wrq !== 1'b0 && n < 20);
    if (wrq !== 1'b0) begin
      err_count++;
      tally_and_finish();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic ports(input logic [3:0] e);
    @(negedge clk);
    chk({28'h0, te, ve, se, je}, {28'h0, e});
  endtask
  task automatic do_reset(input logic [31:0] c, input logic keep);
    @(posedge clk);
    rst_b <= 1'b0;
    ld <= !keep;
    ldv <= c;
    repeat (12) @(posedge clk);
    ld <= 1'b0;
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [3:0] pair(input logic [3:0] c);
    return {c[3], c[2] & !c[0] & !c[3], c[1] & !c[0], c[0]};
  endfunction
  initial begin
    do_reset(32'h0, 1'b0);
    ports(4'h1);
    rchk(OFS_PORT_CFG, 32'hF, 32'h1);
    rchk(OFS_BLK_SEC, 32'hFFFF, 32'hFFFF);
    be <= 4'h2;
    wreg(OFS_BLK_SEC, 32'h0);
    be <= 4'hF;
    rchk(OFS_BLK_SEC, 32'hFFFF, 32'h00FF);
    rchk(5'h18, 32'hFFFFFFFF, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wreg(OFS_PORT_CFG, 32'(c));
      ports(pair(4'(c)));
      rchk(OFS_STATUS, 32'h200, (pair(4'(c)) != 4'(c)) ? 32'h200 : 32'h0);
    end
    wreg(OFS_PORT_CFG, 32'h1);
    wreg(OFS_BLK_SEC, 32'hFFFE);
    wreg(OFS_CMD, 32'h44);
    rchk(OFS_STATUS, 32'h40, 32'h40);
    wreg(OFS_CMD, 32'h1054);
    rchk(OFS_STATUS, 32'h40, 32'h0);
    chk(32'(stb_n), 32'h1);
    chk({25'h0, fop, fblk}, 32'h51);
    wreg(OFS_CMD, 32'h208);
    rchk(OFS_STATUS, 32'h1C0, 32'h100);
    wreg(OFS_CMD, 32'h108);
    rchk(OFS_STATUS, 32'h1C0, 32'h140);
    wreg(OFS_KEY_STAGE, LOCK_PATTERN);
    rchk(OFS_KEY_STAGE, 32'hFFFFFFFF, 32'h0);
    for (int o = 2; o >= 0; o--) wreg(OFS_CMD, 32'(o * 16 + 4));
    rchk(OFS_STATUS, 32'h1C0, 32'h0);
    chk(32'(stb_n), 32'h4);
    wreg(OFS_CMD, 32'h2);
    wreg(OFS_KEY_STAGE, LOCK_PATTERN);
    rchk(OFS_KEY_STAGE, 32'hFFFFFFFF, LOCK_PATTERN);
    chk(32'(er_n), 32'h1);
    wreg(OFS_CMD, 32'h1);
    rchk(OFS_LATCH, 32'hFFFFFFFF, LOCK_PATTERN);
    rchk(OFS_STATUS, 32'h43, 32'h2);
    ports(4'h1);
    wreg(OFS_CMD, 32'h2);
    rchk(OFS_STATUS, 32'h40, 32'h40);
    rchk(OFS_LATCH, 32'hFFFFFFFF, LOCK_PATTERN);
    chk(32'(er_n), 32'h1);
    do_reset(32'h0, 1'b1);
    ports(4'h0);
    wreg(OFS_PORT_CFG, 32'h1);
    ports(4'h0);
    rchk(OFS_LATCH, 32'hFFFFFFFF, LOCK_PATTERN);
    @(posedge clk);
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    rchk(OFS_STATUS, 32'h3, 32'h1);
    ports(4'h0);
    for (int k = 4; k < 6; k++) begin
      do_reset(LOCK_PATTERN ^ ((32'h1 << k) - 32'h1), 1'b0);
      ports(k == 4 ? 4'h0 : 4'h1);
    end
    tally_and_finish();
  end
endmodule
